// ### tsfa_pkg.sv
// Shared constants for the temperature alarm and queue register slice
package tsfa_pkg;
	// Register offsets on the serial register port
	localparam logic [7:0] TSFA_ADDR_STATUS = 8'h00; // Status flags
	localparam logic [7:0] TSFA_ADDR_QUEUE_DATA = 8'h08; // Queue read port
	localparam logic [7:0] TSFA_ADDR_AF_LEVEL = 8'h09; // Almost-full level
	localparam logic [7:0] TSFA_ADDR_QUEUE_CTRL = 8'h0a; // Queue behaviour
	localparam logic [7:0] TSFA_ADDR_SOFT_RESET = 8'h0c; // Soft reset
	localparam logic [7:0] TSFA_ADDR_OVR_HI = 8'h10; // Over limit MSB
	localparam logic [7:0] TSFA_ADDR_OVR_LO = 8'h11; // Over limit LSB
	localparam logic [7:0] TSFA_ADDR_UND_HI = 8'h12; // Under limit MSB
	localparam logic [7:0] TSFA_ADDR_UND_LO = 8'h13; // Under limit LSB
	// Field positions
	localparam int TSFA_POS_AFULL = 7; // Status almost-full
	localparam int TSFA_POS_UNDER = 2; // Status under limit
	localparam int TSFA_POS_OVER = 1; // Status over limit
	localparam int TSFA_POS_FLUSH = 4; // Queue ctrl flush
	localparam int TSFA_POS_STAT_CLR = 3; // Queue ctrl clear on data read
	localparam int TSFA_POS_AF_TYPE = 2; // Queue ctrl almost-full type
	localparam int TSFA_POS_ROLLOVER = 1; // Queue ctrl rollover
	localparam int TSFA_POS_SOFT_RST = 0; // Soft reset bit
	// Writable masks
	localparam logic [7:0] TSFA_MASK_AF_LEVEL = 8'h1f; // Level is 5 bits
	localparam logic [7:0] TSFA_MASK_QUEUE_CTRL = 8'h1e; // Bits 4..1
	// Reset values
	localparam logic [7:0] TSFA_RST_QUEUE_DATA = 8'h00;
	localparam logic [7:0] TSFA_RST_AF_LEVEL = 8'h0f;
	localparam logic [7:0] TSFA_RST_QUEUE_CTRL = 8'h00;
	localparam logic [7:0] TSFA_RST_OVR_HI = 8'h7f;
	localparam logic [7:0] TSFA_RST_OVR_LO = 8'hff;
	localparam logic [7:0] TSFA_RST_UND_HI = 8'h80;
	localparam logic [7:0] TSFA_RST_UND_LO = 8'h00;
	localparam logic [15:0] TSFA_RST_OVR_THR = 16'h7fff; // Alarm disabled
	localparam logic [15:0] TSFA_RST_UND_THR = 16'h8000; // Alarm disabled
endpackage

// ### tsfa_limit_cmp.sv
// Signed threshold comparator raising over and under limit events
`timescale 1ns/1ps
`default_nettype none
module tsfa_limit_cmp (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	input wire logic sample_valid_in,
	input wire logic [15:0] sample_in,
	input wire logic [15:0] over_thr_in,
	input wire logic [15:0] under_thr_in,
	output logic over_evt_out,
	output logic under_evt_out
);
	// Registered compare; signed so 0x7fff is top and 0x8000 bottom
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			over_evt_out <= 1'b0;
			under_evt_out <= 1'b0;
		end else if (ce_in) begin
			// Only a fresh measurement can raise an event
			over_evt_out <= sample_valid_in &&
				($signed(sample_in) > $signed(over_thr_in)); // R7 R10
			under_evt_out <= sample_valid_in &&
				($signed(sample_in) < $signed(under_thr_in)); // R8 R10
		end
	end
endmodule
`default_nettype wire

// ### tsfa_regs.sv
// Register slice: queue port, queue config, soft reset, alarm limits
//
// Contract
// R1: Soft reset bit returns registers to defaults
// R2: Soft reset bit self-clears, write-only, resets 0
// R3: Over limit is MSB 0x10, LSB 0x11
// R4: Over limit defaults to 0x7fff
// R5: Under limit is MSB 0x12 plus LSB
// R6: Under limit defaults to 0x8000
// R7: Over flag sets above limit, status read clears
// R8: Under flag sets below limit, status read clears
// R9: Queue read clears almost-full when enabled
// R10: Limits compare as signed values
`timescale 1ns/1ps
`default_nettype none
module tsfa_regs
	import tsfa_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic [7:0] queue_data_in,
	output logic queue_pop_out,
	input wire logic almost_full_evt_in,
	input wire logic sample_valid_in,
	input wire logic [15:0] sample_in,
	output logic [4:0] almost_full_level_out,
	output logic queue_flush_out,
	output logic status_clear_on_queue_read_out,
	output logic almost_full_type_out,
	output logic queue_rollover_enable_out,
	output logic [15:0] over_limit_threshold_out,
	output logic [15:0] under_limit_threshold_out,
	output logic over_limit_flag_out,
	output logic under_limit_flag_out,
	output logic almost_full_flag_out,
	output logic soft_reset_out
);
	import tsfa_pkg::*;

	// Stored register bytes
	logic [7:0] af_level_q; // Almost-full level
	logic [7:0] queue_ctrl_q; // Queue behaviour bits
	logic [7:0] over_limit_upper_byte_q;
	logic [7:0] over_limit_lower_byte_q;
	logic [7:0] under_limit_upper_byte_q;
	logic [7:0] under_limit_lower_byte_q;
	logic soft_rst_q; // One-cycle soft reset request
	logic over_evt; // Comparator events
	logic under_evt;
	logic rd_status; // Decoded accesses
	logic rd_queue;

	// Decode one access against one offset
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	assign rd_status = reg_rd_in && hit(reg_addr_in, TSFA_ADDR_STATUS);
	assign rd_queue = reg_rd_in && hit(reg_addr_in, TSFA_ADDR_QUEUE_DATA);

	// Write-only soft reset; never reads back, drops after one cycle
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			soft_rst_q <= 1'b0;
		end else if (ce_in) begin
			soft_rst_q <= !soft_rst_q && reg_wr_in && // R2
				hit(reg_addr_in, TSFA_ADDR_SOFT_RESET) &&
				reg_wdata_in[TSFA_POS_SOFT_RST];
		end
	end

	// Configuration and threshold bytes; soft reset beats a write
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			af_level_q <= TSFA_RST_AF_LEVEL;
			queue_ctrl_q <= TSFA_RST_QUEUE_CTRL;
			over_limit_upper_byte_q <= TSFA_RST_OVR_HI;
			over_limit_lower_byte_q <= TSFA_RST_OVR_LO;
			under_limit_upper_byte_q <= TSFA_RST_UND_HI;
			under_limit_lower_byte_q <= TSFA_RST_UND_LO;
		end else if (ce_in) begin
			if (soft_rst_q) begin
				// Back to power-on values
				af_level_q <= TSFA_RST_AF_LEVEL; // R1
				queue_ctrl_q <= TSFA_RST_QUEUE_CTRL; // R1
				over_limit_upper_byte_q <= TSFA_RST_OVR_HI; // R4
				over_limit_lower_byte_q <= TSFA_RST_OVR_LO; // R4
				under_limit_upper_byte_q <= TSFA_RST_UND_HI; // R6
				under_limit_lower_byte_q <= TSFA_RST_UND_LO; // R6
			end else if (reg_wr_in) begin
				case (reg_addr_in)
					TSFA_ADDR_AF_LEVEL: begin
						af_level_q <= reg_wdata_in & TSFA_MASK_AF_LEVEL;
					end
					TSFA_ADDR_QUEUE_CTRL: begin
						queue_ctrl_q <= reg_wdata_in & TSFA_MASK_QUEUE_CTRL;
					end
					TSFA_ADDR_OVR_HI: begin
						over_limit_upper_byte_q <= reg_wdata_in; // R3
					end
					TSFA_ADDR_OVR_LO: begin
						over_limit_lower_byte_q <= reg_wdata_in; // R3
					end
					TSFA_ADDR_UND_HI: begin
						under_limit_upper_byte_q <= reg_wdata_in; // R5
					end
					TSFA_ADDR_UND_LO: begin
						under_limit_lower_byte_q <= reg_wdata_in; // R5
					end
					default: begin
						// Read-only or unmapped: write ignored
					end
				endcase
			end
		end
	end

	// Limits as single 16-bit values, MSB byte on top
	assign over_limit_threshold_out =
		{over_limit_upper_byte_q, over_limit_lower_byte_q}; // R3
	assign under_limit_threshold_out =
		{under_limit_upper_byte_q, under_limit_lower_byte_q}; // R5
	assign almost_full_level_out = af_level_q[4:0];
	assign queue_flush_out = queue_ctrl_q[TSFA_POS_FLUSH];
	assign status_clear_on_queue_read_out = queue_ctrl_q[TSFA_POS_STAT_CLR];
	assign almost_full_type_out = queue_ctrl_q[TSFA_POS_AF_TYPE];
	assign queue_rollover_enable_out = queue_ctrl_q[TSFA_POS_ROLLOVER];
	assign soft_reset_out = soft_rst_q;

	// Signed comparison lives in its own unit
	tsfa_limit_cmp u_cmp (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.ce_in(ce_in),
		.sample_valid_in(sample_valid_in),
		.sample_in(sample_in),
		.over_thr_in(over_limit_threshold_out),
		.under_thr_in(under_limit_threshold_out),
		.over_evt_out(over_evt),
		.under_evt_out(under_evt)
	);

	// Sticky status flags; a same-cycle event outlives the clear
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			over_limit_flag_out <= 1'b0;
			under_limit_flag_out <= 1'b0;
			almost_full_flag_out <= 1'b0;
		end else if (ce_in) begin
			if (soft_rst_q) begin
				// Soft reset clears status too
				over_limit_flag_out <= 1'b0; // R1
				under_limit_flag_out <= 1'b0; // R1
				almost_full_flag_out <= 1'b0; // R1
			end else begin
				over_limit_flag_out <= over_evt ||
					(over_limit_flag_out && !rd_status); // R7
				under_limit_flag_out <= under_evt ||
					(under_limit_flag_out && !rd_status); // R8
				almost_full_flag_out <= almost_full_evt_in ||
					(almost_full_flag_out && !rd_status &&
					!(rd_queue && queue_ctrl_q[TSFA_POS_STAT_CLR])); // R9
			end
		end
	end

	// Read data and queue pop; registered, one cycle after the request
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= TSFA_RST_QUEUE_DATA;
			queue_pop_out <= 1'b0;
		end else if (ce_in) begin
			queue_pop_out <= rd_queue;
			if (reg_rd_in) begin
				case (reg_addr_in)
					TSFA_ADDR_STATUS: begin
						// Flags as held before this read clears them
						reg_rdata_out <= {almost_full_flag_out, 4'h0,
							under_limit_flag_out, over_limit_flag_out, 1'b0};
					end
					TSFA_ADDR_QUEUE_DATA: reg_rdata_out <= queue_data_in;
					TSFA_ADDR_AF_LEVEL: reg_rdata_out <= af_level_q;
					TSFA_ADDR_QUEUE_CTRL: reg_rdata_out <= queue_ctrl_q;
					TSFA_ADDR_OVR_HI: reg_rdata_out <= over_limit_upper_byte_q;
					TSFA_ADDR_OVR_LO: reg_rdata_out <= over_limit_lower_byte_q;
					TSFA_ADDR_UND_HI: reg_rdata_out <= under_limit_upper_byte_q;
					TSFA_ADDR_UND_LO: reg_rdata_out <= under_limit_lower_byte_q;
					default: reg_rdata_out <= 8'h00; // Write-only or unmapped
				endcase
			end
		end
	end

	// Checks
	property p_soft_self_clear;
		@(posedge clk_in) disable iff (sys_rst_in)
		soft_rst_q |=> !soft_rst_q;
	endproperty
	a_soft_self_clear: assert property (p_soft_self_clear) // R2
		else $error("soft reset bit did not self-clear");

	property p_soft_defaults;
		@(posedge clk_in) disable iff (sys_rst_in)
		(ce_in && reg_wr_in && reg_addr_in == TSFA_ADDR_SOFT_RESET &&
		reg_wdata_in[TSFA_POS_SOFT_RST] && !soft_rst_q) ##1 ce_in |=>
		af_level_q == TSFA_RST_AF_LEVEL && !over_limit_flag_out;
	endproperty
	a_soft_defaults: assert property (p_soft_defaults) // R1
		else $error("soft reset did not restore defaults");

	property p_over_default;
		@(posedge clk_in) disable iff (sys_rst_in)
		soft_rst_q && ce_in |=>
		over_limit_threshold_out == TSFA_RST_OVR_THR;
	endproperty
	a_over_default: assert property (p_over_default) // R4
		else $error("over limit default wrong");

	property p_under_default;
		@(posedge clk_in) disable iff (sys_rst_in)
		soft_rst_q && ce_in |=>
		under_limit_threshold_out == TSFA_RST_UND_THR;
	endproperty
	a_under_default: assert property (p_under_default) // R6
		else $error("under limit default wrong");

	property p_over_msb_write;
		@(posedge clk_in) disable iff (sys_rst_in)
		ce_in && !soft_rst_q && reg_wr_in && reg_addr_in == TSFA_ADDR_OVR_HI
		|=> over_limit_threshold_out[15:8] == $past(reg_wdata_in);
	endproperty
	a_over_msb_write: assert property (p_over_msb_write) // R3
		else $error("over limit MSB not placed high");

	property p_under_msb_write;
		@(posedge clk_in) disable iff (sys_rst_in)
		ce_in && !soft_rst_q && reg_wr_in && reg_addr_in == TSFA_ADDR_UND_HI
		|=> under_limit_threshold_out[15:8] == $past(reg_wdata_in);
	endproperty
	a_under_msb_write: assert property (p_under_msb_write) // R5
		else $error("under limit MSB not placed high");

	property p_over_set;
		@(posedge clk_in) disable iff (sys_rst_in)
		(ce_in && sample_valid_in &&
		$signed(sample_in) > $signed(over_limit_threshold_out))
		##1 (ce_in && !soft_rst_q) |=> over_limit_flag_out;
	endproperty
	a_over_set: assert property (p_over_set) // R10
		else $error("over limit flag missed a signed exceed");

	property p_under_set;
		@(posedge clk_in) disable iff (sys_rst_in)
		(ce_in && sample_valid_in &&
		$signed(sample_in) < $signed(under_limit_threshold_out))
		##1 (ce_in && !soft_rst_q) |=> under_limit_flag_out;
	endproperty
	a_under_set: assert property (p_under_set) // R8
		else $error("under limit flag missed a signed drop");

	property p_status_clear;
		@(posedge clk_in) disable iff (sys_rst_in)
		ce_in && rd_status && !over_evt |=> !over_limit_flag_out;
	endproperty
	a_status_clear: assert property (p_status_clear) // R7
		else $error("status read did not clear over flag");

	property p_af_queue_clear;
		@(posedge clk_in) disable iff (sys_rst_in)
		ce_in && rd_queue && status_clear_on_queue_read_out &&
		!almost_full_evt_in |=> !almost_full_flag_out && queue_pop_out;
	endproperty
	a_af_queue_clear: assert property (p_af_queue_clear) // R9
		else $error("queue read did not clear almost-full");

	c_soft_reset: cover property (@(posedge clk_in) soft_rst_q);
	c_over_flag: cover property (@(posedge clk_in) over_limit_flag_out);
	c_under_flag: cover property (@(posedge clk_in) under_limit_flag_out);
	c_af_cleared: cover property (@(posedge clk_in)
		almost_full_flag_out && rd_queue ##1 !almost_full_flag_out);
endmodule
`default_nettype wire

// ### tsfa_host.sv
// Host-side model driving the register port in place of the serial engine
`timescale 1ns/1ps
`default_nettype none
module tsfa_host (
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	output logic [7:0] addr_out,
	output logic wr_out,
	output logic [7:0] wdata_out,
	output logic rd_out
);
	// Idle lines carry inverted bytes so a stale value never looks valid
	initial begin
		addr_out = 8'hff;
		wr_out = 1'b0;
		wdata_out = 8'h00;
		rd_out = 1'b0;
	end
	// One write strobe; an idle cycle always separates two strobes
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(negedge clk_in);
		wr_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
	endtask
	// Read strobe; the byte is taken once the answering edge has passed
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_in);
		addr_out = a;
		rd_out = 1'b1;
		@(negedge clk_in);
		rd_out = 1'b0;
		addr_out = ~a;
		d = rdata_in;
	endtask
endmodule
`default_nettype wire

// ### temp_sensor_fifo_alarm_regs_test.sv
// Self-checking testbench for the alarm and queue register slice
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_fifo_alarm_regs_test;
	import tsfa_pkg::*;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic ce_in = 1'b1;
	logic [7:0] addr, wdata, rdata, qdata = 8'h00;
	logic wr, rd, pop, af_evt = 1'b0, s_vld = 1'b0;
	logic [15:0] smp = 16'h0000, over_thr, under_thr;
	logic [4:0] af_lvl;
	logic flush, stat_clr, af_type, roll, over_f, under_f, af_f, srst;
	logic [7:0] d;
	int err_total = 0;
	int num_checks = 0;
	// 100 MHz clock
	always #5 clk_in = ~clk_in;
	tsfa_host i_host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
		.wr_out(wr), .wdata_out(wdata), .rd_out(rd));
	tsfa_regs i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
		.reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
		.reg_rd_in(rd), .reg_rdata_out(rdata), .queue_data_in(qdata),
		.queue_pop_out(pop), .almost_full_evt_in(af_evt),
		.sample_valid_in(s_vld), .sample_in(smp),
		.almost_full_level_out(af_lvl), .queue_flush_out(flush),
		.status_clear_on_queue_read_out(stat_clr),
		.almost_full_type_out(af_type), .queue_rollover_enable_out(roll),
		.over_limit_threshold_out(over_thr),
		.under_limit_threshold_out(under_thr),
		.over_limit_flag_out(over_f), .under_limit_flag_out(under_f),
		.almost_full_flag_out(af_f), .soft_reset_out(srst));
	// Compare any value up to 16 bits
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One measurement pulse, then time for the flag to land
	task automatic send(input logic [15:0] s);
		@(negedge clk_in);
		smp = s;
		s_vld = 1'b1;
		@(negedge clk_in);
		s_vld = 1'b0;
		smp = ~s;
		repeat (3) @(negedge clk_in);
	endtask
	// Register defaults, by read-back and at the outputs
	task automatic t_defaults;
		logic [7:0] a[9] = '{8'h00, 8'h08, 8'h09, 8'h0a, 8'h0c, 8'h10,
			8'h11, 8'h12, 8'h13};
		logic [7:0] e[9] = '{8'h00, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h7f,
			8'hff, 8'h80, 8'h00};
		qdata = 8'h00;
		for (int i = 0; i < 9; i++) begin
			i_host.rd_reg(a[i], d);
			chk(d, e[i]);
		end
		chk(over_thr, 16'h7fff);
		chk(under_thr, 16'h8000);
		chk({flush, stat_clr, af_type, roll, af_lvl}, 9'h00f);
		$display("test defaults done");
	endtask
	// Byte pairs form the thresholds; signed compare drives the flags
	task automatic t_alarms;
		i_host.wr_reg(8'h10, 8'h01);
		i_host.wr_reg(8'h11, 8'h00);
		i_host.wr_reg(8'h12, 8'hff);
		i_host.wr_reg(8'h13, 8'h00);
		chk(over_thr, 16'h0100);
		chk(under_thr, 16'hff00);
		send(16'h0100);
		chk({over_f, under_f}, 2'b00);
		send(16'h0101);
		chk({over_f, under_f}, 2'b10);
		i_host.rd_reg(8'h00, d);
		chk(d, 8'h02);
		chk(over_f, 1'b0);
		// Unsigned compare would wrongly see this as over the limit
		send(16'hfeff);
		chk({over_f, under_f}, 2'b01);
		i_host.rd_reg(8'h00, d);
		chk(d, 8'h04);
		chk(under_f, 1'b0);
		$display("test alarms done");
	endtask
	// Queue read port, almost-full clearing, refused writes
	task automatic t_queue;
		qdata = 8'ha5;
		@(negedge clk_in);
		af_evt = 1'b1;
		@(negedge clk_in);
		af_evt = 1'b0;
		i_host.rd_reg(8'h08, d);
		chk(d, 8'ha5);
		chk(pop, 1'b1);
		chk(af_f, 1'b1);
		i_host.wr_reg(8'h0a, 8'hff);
		i_host.rd_reg(8'h0a, d);
		chk(d, 8'h1e);
		chk({flush, stat_clr, af_type, roll}, 4'hf);
		i_host.rd_reg(8'h08, d);
		chk(af_f, 1'b0);
		// Status read clears almost-full too
		@(negedge clk_in);
		af_evt = 1'b1;
		@(negedge clk_in);
		af_evt = 1'b0;
		i_host.rd_reg(8'h00, d);
		chk(d, 8'h80);
		chk(af_f, 1'b0);
		i_host.wr_reg(8'h08, 8'h33);
		i_host.wr_reg(8'h40, 8'h33);
		i_host.rd_reg(8'h40, d);
		chk(d, 8'h00);
		$display("test queue done");
	endtask
	// Soft reset restores defaults and clears itself
	task automatic t_soft_reset;
		i_host.wr_reg(8'h09, 8'hff);
		i_host.rd_reg(8'h09, d);
		chk(d, 8'h1f);
		chk(af_lvl, 5'h1f);
		i_host.wr_reg(8'h12, 8'h00);
		// A frozen clock enable must drop a write
		ce_in = 1'b0;
		i_host.wr_reg(8'h11, 8'h55);
		ce_in = 1'b1;
		chk(over_thr, 16'h0100);
		send(16'hffff);
		chk(under_f, 1'b1);
		i_host.wr_reg(8'h0c, 8'h01);
		chk(srst, 1'b1);
		@(negedge clk_in);
		chk(srst, 1'b0);
		chk(under_f, 1'b0);
		t_defaults();
		$display("test soft reset done");
	endtask
	// Summary and verdict; the only place the run ends
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Watchdog well beyond the hundred or so cycles the tests need
	initial begin
		#100us;
		err_total++;
		$display("MISMATCH %0t watchdog expired", $time);
		print_verdict();
	end
	// Main sequence
	initial begin
		repeat (8) @(negedge clk_in);
		sys_rst_in = 1'b0;
		t_defaults();
		t_alarms();
		t_queue();
		t_soft_reset();
		print_verdict();
	end
endmodule
`default_nettype wire
